// File: hw/pin_hold_latch.sv
`timescale 1ns/100ps
module pin_hold_latch #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic hold,
  // Pin control from the ports
  input wire logic [WIDTH-1:0] padOutIn,
  input wire logic [WIDTH-1:0] padOeIn,
  // Pin control to the pads
  output logic [WIDTH-1:0] padOut,
  output logic [WIDTH-1:0] padOe
);
  logic [WIDTH-1:0] outQ;
  logic [WIDTH-1:0] oeQ;

  initial begin
    if (WIDTH < 1) $error("pin_hold_latch: WIDTH must be at least 1");
  end

  // Each pin keeps its last value while hold is high.
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          outQ[i] <= 1'b0;
          oeQ[i] <= 1'b0;
        end else if (!hold) begin
          outQ[i] <= padOutIn[i];
          oeQ[i] <= padOeIn[i];
        end
      end
    end
  endgenerate

  assign padOut = outQ;
  assign padOe = oeQ;
endmodule

// File: hw/stop_mode_power_control.sv
`timescale 1ns/100ps
// Function
// - Background entry from run only when debug_enable_in_stop is set.
// - Stop with debug enabled keeps the debug clock running.
// - Stop with debug enabled keeps the regulator in full regulation.
// - In stop, reject debug commands except a halt in stop3 with debug enabled; memory status commands report stop error.
// - Halt command wakes stop3 into active background when debug enabled.
// - In active background all debug commands are accepted.
// - Stop instruction with stop2 conditions enters stop2.
// - Stop2 powers down all but RAM.
// - Entering stop2 latches all pin controls.
// - Stop2 exits on reset pin, or on enabled real-time counter wake.
// - Older masks: low external wake pin also exits stop2.
// - Stop2 wake restarts like power-on and resets module registers.
// - Stop2 wake enables low-voltage reset, held while supply below trip.
// - After stop2 wake the core fetches the reset vector.
// - Stop2 wake sets partial_powerdown_flag.
// - Flag and pin latch stay until powerdown_acknowledge is written 1.
module stop_mode_power_control #(
  parameter int PIN_COUNT = stop_power_pkg::PIN_COUNT,
  parameter bit OLD_MASK = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // CPU
  input wire logic stopExec,
  input wire logic stop2Select,
  input wire logic debugEnableWrite,
  input wire logic debugEnableData,
  input wire logic powerdownAckWrite,
  input wire logic powerdownAckData,
  // Wake and supply sources, asynchronous
  input wire logic resetPinN,
  input wire logic rtcWake,
  input wire logic rtcEnable,
  input wire logic externalWakePinN,
  input wire logic supplyBelowTrip,
  // Debug host commands
  input wire logic cmdValid,
  input wire logic [1:0] cmdClass,
  output logic cmdAccept,
  output logic [1:0] cmdResponse,
  // Pin control
  input wire logic [PIN_COUNT-1:0] padOutIn,
  input wire logic [PIN_COUNT-1:0] padOeIn,
  output logic [PIN_COUNT-1:0] padOut,
  output logic [PIN_COUNT-1:0] padOe,
  // Power and status
  output logic debugEnableInStop,
  output logic debugClockOn,
  output logic regulatorFull,
  output logic coreClockOn,
  output logic domainPowerOn,
  output logic ramPowerOn,
  output logic moduleResetOut,
  output logic resetVectorFetch,
  output logic lowVoltageResetEn,
  output logic partialPowerdownFlag,
  output logic pinsLatched,
  output logic inStop,
  output logic inBackground
);
  stop_power_pkg::power_state_t state_q;
  stop_power_pkg::power_state_t state_d;
  logic [3:0] wakeCnt_q;
  logic debugEn_q;
  logic ppdFlag_q;
  logic hold_q;
  logic cmdAccept_q;
  logic [1:0] cmdResponse_q;
  logic vecFetch_q;
  logic lvdEn_q;
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic resetPinNS;
  logic rtcWakeS;
  logic extWakeNS;
  logic lowSupplyS;
  logic stop2Wake;
  logic ackPulse;

  initial begin
    if (PIN_COUNT < 1) $error("stop_mode_power_control: PIN_COUNT must be at least 1");
    if (stop_power_pkg::WAKE_RESET_CYCLES < 1 || stop_power_pkg::WAKE_RESET_CYCLES > 16) begin
      $error("stop_mode_power_control: WAKE_RESET_CYCLES must be 1 to 16");
    end
  end

  // Two-stage synchronisers for the asynchronous sources.
  // They reset to the idle level of each source, so no false wake follows reset.
  // Only the second stage reads the first, and the logic reads only the second.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA_q <= 4'hA;
      syncB_q <= 4'hA;
    end else begin
      syncA_q <= {resetPinN, rtcWake, externalWakePinN, supplyBelowTrip};
      syncB_q <= syncA_q;
    end
  end
  assign resetPinNS = syncB_q[3];
  assign rtcWakeS = syncB_q[2];
  assign extWakeNS = syncB_q[1];
  assign lowSupplyS = syncB_q[0];

  // A wake is acted on only in stop2; in other states the sources are ignored.
  // The wake pin counts only on older masks, which OLD_MASK selects.
  assign stop2Wake = !resetPinNS || (rtcEnable && rtcWakeS)
    || (OLD_MASK && !extWakeNS);
  assign ackPulse = powerdownAckWrite && powerdownAckData;

  // Next state. Stop with debug enabled always takes stop3, so the debug link stays up.
  // Stop2 is only reachable with debug disabled, as its clocks are all removed.
  always_comb begin
    state_d = state_q;
    case (state_q)
      stop_power_pkg::RUN: begin
        if (stopExec && stop2Select && !debugEn_q) begin
          state_d = stop_power_pkg::STOP2;
        end else if (stopExec) begin
          state_d = stop_power_pkg::STOP3;
        end else if (cmdValid && cmdClass == stop_power_pkg::CMD_HALT && debugEn_q) begin
          state_d = stop_power_pkg::DEBUG;
        end
      end
      stop_power_pkg::STOP3: begin
        if (cmdValid && cmdClass == stop_power_pkg::CMD_HALT && debugEn_q) begin
          state_d = stop_power_pkg::DEBUG;
        end
      end
      stop_power_pkg::STOP2: begin
        if (stop2Wake) begin
          state_d = stop_power_pkg::WAKE_RST;
        end
      end
      stop_power_pkg::WAKE_RST: begin
        // Leave only once the hold-off has run out and the supply is good.
        if (wakeCnt_q == 4'h0 && !lowSupplyS) begin
          state_d = stop_power_pkg::RUN;
        end
      end
      stop_power_pkg::DEBUG: begin
        // Clearing the debug enable ends the background session.
        if (!debugEn_q) begin
          state_d = stop_power_pkg::RUN;
        end
      end
      default: state_d = stop_power_pkg::RUN;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= stop_power_pkg::RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold-off counter for the power-on style restart.
  // It reloads on every stop2 cycle, so the count always starts full at wake.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wakeCnt_q <= 4'h0;
    end else if (state_q == stop_power_pkg::STOP2) begin
      wakeCnt_q <= 4'(stop_power_pkg::WAKE_RESET_CYCLES - 1);
    end else if (wakeCnt_q != 4'h0) begin
      wakeCnt_q <= wakeCnt_q - stop_power_pkg::WAKE_CNT_WIDTH_ONE;
    end
  end

  // Debug enable returns to reset value on the stop2 restart.
  // Clearing it through the whole wake reset also blocks writes while the core is held.
  always_ff @(posedge ref_clk) begin
    if (rst || state_q == stop_power_pkg::WAKE_RST) begin
      debugEn_q <= stop_power_pkg::DEBUG_EN_RESET;
    end else if (debugEnableWrite) begin
      debugEn_q <= debugEnableData;
    end
  end

  // Recovery flag: set on wake wins over acknowledge.
  // Software reads it after the restart to choose the stop2 recovery path.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ppdFlag_q <= stop_power_pkg::PPD_FLAG_RESET;
    end else if (state_q == stop_power_pkg::STOP2 && state_d == stop_power_pkg::WAKE_RST) begin
      ppdFlag_q <= 1'b1;
    end else if (ackPulse) begin
      ppdFlag_q <= 1'b0;
    end
  end

  // Pin hold spans stop2 and the recovery until acknowledged.
  // Releasing only in run keeps the pads frozen through the whole wake reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q <= 1'b0;
    end else if (state_q == stop_power_pkg::RUN && state_d == stop_power_pkg::STOP2) begin
      hold_q <= 1'b1;
    end else if (ackPulse && state_q == stop_power_pkg::RUN) begin
      hold_q <= 1'b0;
    end
  end

  // Low-voltage reset enable and reset vector fetch after stop2 wake.
  // The enable comes up set from reset and nothing in this block turns it off.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvdEn_q <= 1'b1;
      vecFetch_q <= 1'b0;
    end else begin
      if (state_q == stop_power_pkg::WAKE_RST) begin
        lvdEn_q <= 1'b1;
      end
      vecFetch_q <= (state_q == stop_power_pkg::WAKE_RST)
        && (state_d == stop_power_pkg::RUN);
    end
  end

  // Debug command answers, one cycle after the request.
  // Class three means no command, so the answer lines go quiet.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmdAccept_q <= 1'b0;
      cmdResponse_q <= stop_power_pkg::RSP_OK;
    end else if (!cmdValid || cmdClass == stop_power_pkg::CMD_NONE) begin
      cmdAccept_q <= 1'b0;
      cmdResponse_q <= stop_power_pkg::RSP_OK;
    end else begin
      case (state_q)
        stop_power_pkg::DEBUG: begin
          cmdAccept_q <= 1'b1;
          cmdResponse_q <= stop_power_pkg::RSP_OK;
        end
        stop_power_pkg::STOP3, stop_power_pkg::STOP2: begin
          // In stop only a halt in stop3 with debug enabled is served.
          if (cmdClass == stop_power_pkg::CMD_HALT && state_q == stop_power_pkg::STOP3
              && debugEn_q) begin
            cmdAccept_q <= 1'b1;
            cmdResponse_q <= stop_power_pkg::RSP_OK;
          end else if (cmdClass == stop_power_pkg::CMD_MEM_STATUS) begin
            cmdAccept_q <= 1'b0;
            cmdResponse_q <= stop_power_pkg::RSP_STOP_ERR;
          end else begin
            cmdAccept_q <= 1'b0;
            cmdResponse_q <= stop_power_pkg::RSP_REJECT;
          end
        end
        stop_power_pkg::RUN: begin
          // In run only an enabled debug link is served.
          cmdAccept_q <= debugEn_q;
          cmdResponse_q <= debugEn_q ? stop_power_pkg::RSP_OK : stop_power_pkg::RSP_REJECT;
        end
        default: begin
          cmdAccept_q <= 1'b0;
          cmdResponse_q <= stop_power_pkg::RSP_REJECT;
        end
      endcase
    end
  end

  // The pads are captured on the entry edge, while hold is still low.
  pin_hold_latch #(
    .WIDTH(PIN_COUNT)
  ) u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .hold(hold_q),
    .padOutIn(padOutIn),
    .padOeIn(padOeIn),
    .padOut(padOut),
    .padOe(padOe)
  );

  // The debug enable is visible to the host as it stands.
  assign debugEnableInStop = debugEn_q;

  // Clock and regulator stay up in stop3 only when debug is enabled.
  assign debugClockOn = (state_q != stop_power_pkg::STOP2)
    && (state_q != stop_power_pkg::STOP3 || debugEn_q);
  assign regulatorFull = (state_q != stop_power_pkg::STOP2)
    && (state_q != stop_power_pkg::STOP3 || debugEn_q);
  // The core runs in run only; background and both stops halt it.
  assign coreClockOn = (state_q == stop_power_pkg::RUN);
  assign domainPowerOn = (state_q != stop_power_pkg::STOP2);
  // RAM keeps power in every state, so its contents survive stop2.
  assign ramPowerOn = 1'b1;
  // The module reset covers the wake hold-off and a low supply while enabled.
  assign moduleResetOut = (state_q == stop_power_pkg::WAKE_RST)
    || (lvdEn_q && lowSupplyS);

  // Registered status and answers.
  assign resetVectorFetch = vecFetch_q;
  assign lowVoltageResetEn = lvdEn_q;
  assign partialPowerdownFlag = ppdFlag_q;
  assign pinsLatched = hold_q;
  assign inStop = (state_q == stop_power_pkg::STOP2) || (state_q == stop_power_pkg::STOP3);
  assign inBackground = (state_q == stop_power_pkg::DEBUG);
  assign cmdAccept = cmdAccept_q;
  assign cmdResponse = cmdResponse_q;
endmodule

// File: inc/stop_power_pkg.sv
package stop_power_pkg;
  localparam int PIN_COUNT = 8;
  // Cycles the sequencer holds the core in reset after a stop2 wake.
  localparam int WAKE_RESET_CYCLES = 4;
  localparam logic [3:0] WAKE_CNT_WIDTH_ONE = 4'h1;
  localparam logic PPD_FLAG_RESET = 1'b0;
  localparam logic DEBUG_EN_RESET = 1'b0;
  // Debug command classes seen by the sequencer.
  localparam logic [1:0] CMD_OTHER = 2'h0;
  localparam logic [1:0] CMD_MEM_STATUS = 2'h1;
  localparam logic [1:0] CMD_HALT = 2'h2;
  localparam logic [1:0] CMD_NONE = 2'h3;
  // Answer codes for a debug command.
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_REJECT = 2'h1;
  localparam logic [1:0] RSP_STOP_ERR = 2'h2;
  typedef enum logic [4:0] {
    RUN = 5'h01,
    STOP3 = 5'h02,
    STOP2 = 5'h04,
    WAKE_RST = 5'h08,
    DEBUG = 5'h10
  } power_state_t;
endpackage

// File: testbench/debug_host_model.sv
`timescale 1ns/100ps
module debug_host_model (
  // Clock
  input wire logic ref_clk,
  // Command link
  output logic cmdValid,
  output logic [1:0] cmdClass,
  input wire logic cmdAccept,
  input wire logic [1:0] cmdResponse
);
  initial begin
    cmdValid = 1'b0;
    cmdClass = stop_power_pkg::CMD_NONE;
  end
  // The answer stands one cycle only, so it is taken at the next falling edge.
  task automatic send(input logic [1:0] cls, output logic acc, output logic [1:0] rsp);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdClass = cls;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    cmdClass = stop_power_pkg::CMD_NONE;
    acc = cmdAccept;
    rsp = cmdResponse;
  endtask
endmodule

// File: testbench/stop_mode_power_control_sva.sv
`timescale 1ns/100ps
module stop_mode_power_control_sva #(
  parameter int PIN_COUNT = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stopExec,
  input wire logic supplyBelowTrip,
  input wire logic cmdValid,
  input wire logic [1:0] cmdClass,
  input wire logic cmdAccept,
  input wire logic [1:0] cmdResponse,
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic debugEnableInStop,
  input wire logic debugClockOn,
  input wire logic regulatorFull,
  input wire logic domainPowerOn,
  input wire logic ramPowerOn,
  input wire logic moduleResetOut,
  input wire logic resetVectorFetch,
  input wire logic lowVoltageResetEn,
  input wire logic partialPowerdownFlag,
  input wire logic pinsLatched,
  input wire logic inStop,
  input wire logic inBackground
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_hold;
    moduleResetOut[*4];
  endsequence
  sequence s_boot;
    !moduleResetOut ##[0:1] resetVectorFetch;
  endsequence
  a_stop_entry: assert property (stopExec && !inStop && !inBackground && !moduleResetOut |=> inStop)
    else $error("stop not entered");
  a_stop2_power: assert property (inStop && !domainPowerOn |-> ramPowerOn && pinsLatched && !debugClockOn)
    else $error("stop2 power state wrong");
  a_debug_clock: assert property (inStop && debugEnableInStop |-> debugClockOn && regulatorFull)
    else $error("debug clock or regulator off in stop");
  a_mem_status: assert property (inStop && cmdValid && cmdClass == stop_power_pkg::CMD_MEM_STATUS
    |=> !cmdAccept && cmdResponse == stop_power_pkg::RSP_STOP_ERR)
    else $error("memory status command not refused");
  a_other_reject: assert property (inStop && cmdValid && cmdClass == stop_power_pkg::CMD_OTHER |=> !cmdAccept)
    else $error("command accepted in stop");
  a_halt_wake: assert property (inStop && domainPowerOn && debugEnableInStop && cmdValid
    && cmdClass == stop_power_pkg::CMD_HALT |=> cmdAccept && inBackground)
    else $error("halt did not wake");
  a_bg_accept: assert property (inBackground && cmdValid && cmdClass != stop_power_pkg::CMD_NONE |=> cmdAccept)
    else $error("command refused in background");
  a_run_gate: assert property (!inStop && !inBackground && !moduleResetOut && !debugEnableInStop && cmdValid
    |=> !cmdAccept && !inBackground)
    else $error("background entered while disabled");
  a_wake_flag: assert property ($fell(inStop) && !inBackground
    |-> moduleResetOut && partialPowerdownFlag && lowVoltageResetEn)
    else $error("stop2 wake state wrong");
  a_wake_boot: assert property ($rose(moduleResetOut) && !supplyBelowTrip |-> s_hold ##1 s_boot)
    else $error("wake reset length or vector fetch wrong");
  a_pins_hold: assert property (pinsLatched ##1 pinsLatched |-> $stable(padOut))
    else $error("pins changed while latched");
endmodule
bind stop_mode_power_control stop_mode_power_control_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (.*);

// File: testbench/stop_mode_power_control_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module stop_mode_power_control_tb;
  logic ref_clk = 0, rst = 1, stopExec = 0, stop2Select = 0, acc;
  logic debugEnableWrite = 0, debugEnableData = 0, powerdownAckWrite = 0, powerdownAckData = 0;
  logic resetPinN = 1, rtcWake = 0, rtcEnable = 0, externalWakePinN = 1, supplyBelowTrip = 0;
  logic cmdValid, cmdAccept, debugEnableInStop, debugClockOn, regulatorFull, coreClockOn;
  logic domainPowerOn, ramPowerOn, moduleResetOut, resetVectorFetch, lowVoltageResetEn;
  logic partialPowerdownFlag, pinsLatched, inStop, inBackground;
  logic [1:0] cmdClass, cmdResponse, rsp;
  logic [7:0] padOutIn = 8'h5A, padOeIn = 8'hF0, padOut, padOe;
  int mismatches = 0, check_count = 0, cycles = 0, i;
  always #10 ref_clk = ~ref_clk;
  stop_mode_power_control u_dut (.*);
  debug_host_model u_host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdClass(cmdClass),
    .cmdAccept(cmdAccept), .cmdResponse(cmdResponse));
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic dbg(input logic v);
    @(negedge ref_clk);
    debugEnableWrite = 1;
    debugEnableData = v;
    @(negedge ref_clk);
    debugEnableWrite = 0;
  endtask
  task automatic stop;
    @(negedge ref_clk);
    stopExec = 1;
    stop2Select = 1;
    @(negedge ref_clk);
    stopExec = 0;
  endtask
  task automatic ack(input logic v);
    @(negedge ref_clk);
    powerdownAckWrite = 1;
    powerdownAckData = v;
    @(negedge ref_clk);
    powerdownAckWrite = 0;
  endtask
  task automatic cmd(input logic [1:0] c, input logic ea, input logic [1:0] er);
    u_host.send(c, acc, rsp);
    `CHK("cmdAccept", ea, acc)
    `CHK("cmdResponse", er, rsp)
  endtask
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    cyc(16);
    rst = 0;
    cyc(2);
    cmd(stop_power_pkg::CMD_HALT, 0, stop_power_pkg::RSP_REJECT);
    dbg(1);
    cmd(stop_power_pkg::CMD_HALT, 1, stop_power_pkg::RSP_OK);
    cmd(stop_power_pkg::CMD_MEM_STATUS, 1, stop_power_pkg::RSP_OK);
    dbg(0);
    cyc(2);
    dbg(1);
    stop();
    `CHK("debugClockOn", 1'b1, debugClockOn)
    `CHK("regulatorFull", 1'b1, regulatorFull)
    cmd(stop_power_pkg::CMD_MEM_STATUS, 0, stop_power_pkg::RSP_STOP_ERR);
    cmd(stop_power_pkg::CMD_OTHER, 0, stop_power_pkg::RSP_REJECT);
    cmd(stop_power_pkg::CMD_HALT, 1, stop_power_pkg::RSP_OK);
    `CHK("inBackground", 1'b1, inBackground)
    dbg(0);
    cyc(2);
    // Wake sources in turn: real-time counter with low supply, reset pin, wake pin.
    for (int k = 0; k < 3; k++) begin
      {padOutIn, padOeIn} = 16'h5AF0;
      stop();
      `CHK("domainPowerOn", 1'b0, domainPowerOn)
      `CHK("ramPowerOn", 1'b1, ramPowerOn)
      `CHK("coreClockOn", 1'b0, coreClockOn)
      {padOutIn, padOeIn} = 16'hA50F;
      rtcWake = 1;
      cyc(4);
      `CHK("inStop", 1'b1, inStop)
      `CHK("padOut", 8'h5A, padOut)
      `CHK("padOe", 8'hF0, padOe)
      supplyBelowTrip = (k == 0);
      rtcEnable = (k == 0);
      rtcWake = (k == 0);
      resetPinN = (k != 1);
      externalWakePinN = (k != 2);
      for (i = 0; i < 10 && inStop !== 1'b0; i++) cyc(1);
      `CHK("partialPowerdownFlag", 1'b1, partialPowerdownFlag)
      `CHK("lowVoltageResetEn", 1'b1, lowVoltageResetEn)
      {rtcWake, rtcEnable, resetPinN, externalWakePinN} = 4'h3;
      // A low supply holds the wake reset well past its own hold-off.
      cyc(k == 0 ? 8 : 3);
      `CHK("moduleResetOut", 1'b1, moduleResetOut)
      supplyBelowTrip = 0;
      for (i = 0; i < 20 && resetVectorFetch !== 1'b1; i++) cyc(1);
      `CHK("resetVectorFetch", 1'b1, resetVectorFetch)
      `CHK("coreClockOn", 1'b1, coreClockOn)
      `CHK("debugEnableInStop", 1'b0, debugEnableInStop)
      ack(0);
      `CHK("partialPowerdownFlag", 1'b1, partialPowerdownFlag)
      `CHK("padOut", 8'h5A, padOut)
      ack(1);
      `CHK("partialPowerdownFlag", 1'b0, partialPowerdownFlag)
      cyc(2);
      `CHK("padOut", 8'hA5, padOut)
      `CHK("padOe", 8'h0F, padOe)
    end
    finish_test();
  end
endmodule
